// File: pmsf_pkg.sv
// constants and types shared by both ends of the power-mode and serial front end
package pmsf_pkg;

	// power state field codes
	localparam logic [1:0] PMSF_PS_ACTIVE   = 2'h0;
	localparam logic [1:0] PMSF_PS_STARTUP  = 2'h1;
	localparam logic [1:0] PMSF_PS_LOWPWR   = 2'h2;
	localparam logic [1:0] PMSF_PS_SHUTDOWN = 2'h3;

	// reset values after an io-supply power-on reset
	localparam logic [3:0] PMSF_BOOST_RESET = 4'hF;
	localparam logic [5:0] PMSF_OE_RESET    = 6'h00;

	// serial frame layout: address and data sit in the low bits of either length
	localparam int         PMSF_FRAME_SHORT = 30;
	localparam int         PMSF_FRAME_LONG  = 32;
	localparam int         PMSF_ADDR_LSB    = 16;
	localparam int         PMSF_ADDR_W      = 5;
	localparam logic [4:0] PMSF_ADDR_BOOST  = 5'h02;
	localparam logic [4:0] PMSF_ADDR_OE     = 5'h03;
	localparam logic [4:0] PMSF_ADDR_PMODE  = 5'h04;

	// startup must finish well inside this bound; the sequencer uses one step
	localparam int         PMSF_CLK_MHZ        = 100;
	localparam int         PMSF_STARTUP_MAX_US = 300;
	localparam int         PMSF_STARTUP_MAX_CYC = PMSF_STARTUP_MAX_US * PMSF_CLK_MHZ;

	// host register map (apb byte addresses)
	localparam logic [7:0] PMSF_HOST_CTRL   = 8'h00;
	localparam logic [7:0] PMSF_HOST_TXDATA = 8'h04;
	localparam logic [7:0] PMSF_HOST_STATUS = 8'h08;
	localparam int         PMSF_CTRL_GO     = 8;
	localparam int         PMSF_HALF_CYC    = 4;

	typedef enum logic [1:0] {
		PMSF_SHUTDOWN,
		PMSF_STARTUP,
		PMSF_ACTIVE,
		PMSF_LOWPWR
	} pmsf_mode_t;

	typedef enum logic [2:0] {
		PMSF_H_IDLE,
		PMSF_H_SETUP,
		PMSF_H_LOW,
		PMSF_H_HIGH,
		PMSF_H_HOLD,
		PMSF_H_GAP
	} pmsf_hstate_t;

endpackage : pmsf_pkg

// File: pmsf_link_if.sv
// 3-wire write-only serial link between host and device
`timescale 1ns/1ps
interface pmsf_link_if;
	logic cs;
	logic sclk;
	logic sdata;

	modport host (
		output cs,
		output sclk,
		output sdata
	);

	modport device (
		input cs,
		input sclk,
		input sdata
	);
endinterface : pmsf_link_if

// File: pmsf_device.sv
// device end: power-mode sequencer and 3-wire serial slave
//
// Summary of operation
// - analog supply alone keeps device in shutdown
// - io supply high resets registers, enters startup
// - io power-on reset also clears serial logic
// - no retrigger until io supply seen low
// - defaults: boost all ones, startup then active
// - io supply low anytime: shutdown, registers lost
// - shutdown to active within 300 microseconds
// - starts with defaults, waits in active
// - boost runs in startup and active while boosted voltage below reference
// - shutdown puts all six outputs high impedance
// - frame kind decided anew every frame
// - serial port is write-only slave
// - frame length 30 or 32 judged per frame
// - chip select toggle mid-frame discards bits
// - msb first, sampled on rising clock
// - command executes at chip select falling edge
// - length counts rising edges while select high
// - other lengths ignored entirely
// - power command: low power, or back to startup
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pmsf_device (
	input  wire logic           clk_i,
	input  wire logic           reset_n_i,
	input  wire logic           analog_supply_i,
	input  wire logic           io_supply_i,
	input  wire logic           boosted_voltage_low_i,
	pmsf_link_if.device         link,
	output logic       [3:0]    boost_level_o,
	output logic       [1:0]    power_state_o,
	output logic       [5:0]    output_enable_o,
	output logic       [5:0]    out_hiz_o,
	output logic                boost_run_o,
	output logic                cmd_done_o
);
	import pmsf_pkg::*;

	typedef struct packed {
		pmsf_mode_t  mode;
		logic        armed;
		logic        an_s1;
		logic        an_s2;
		logic        io_s1;
		logic        io_s2;
		logic        vl_s1;
		logic        vl_s2;
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_prev;
		logic        ck_s1;
		logic        ck_s2;
		logic        ck_prev;
		logic        dt_s1;
		logic        dt_s2;
		logic [31:0] shreg;
		logic [5:0]  cnt;
		logic [3:0]  boost;
		logic [5:0]  oe;
		logic [1:0]  pstate;
		logic [5:0]  en_out;
		logic [5:0]  hiz_out;
		logic        boost_run;
		logic        cmd_done;
	} pmsf_dev_t;

	pmsf_dev_t q;
	pmsf_dev_t d;

	logic                   ck_rise;
	logic                   cs_rise;
	logic                   cs_fall;
	logic                   len_ok;
	logic [PMSF_ADDR_W-1:0] addr;
	logic [15:0]            wdata;

	always_comb begin
		ck_rise = q.ck_s2 & ~q.ck_prev;
		cs_rise = q.cs_s2 & ~q.cs_prev;
		cs_fall = ~q.cs_s2 & q.cs_prev;
		len_ok  = (q.cnt == 6'(PMSF_FRAME_SHORT)) || (q.cnt == 6'(PMSF_FRAME_LONG));
		addr    = q.shreg[PMSF_ADDR_LSB +: PMSF_ADDR_W];
		wdata   = q.shreg[15:0];

		d = q;
		d.an_s1    = analog_supply_i;
		d.an_s2    = q.an_s1;
		d.io_s1    = io_supply_i;
		d.io_s2    = q.io_s1;
		d.vl_s1    = boosted_voltage_low_i;
		d.vl_s2    = q.vl_s1;
		d.cs_s1    = link.cs;
		d.cs_s2    = q.cs_s1;
		d.cs_prev  = q.cs_s2;
		d.ck_s1    = link.sclk;
		d.ck_s2    = q.ck_s1;
		d.ck_prev  = q.ck_s2;
		d.dt_s1    = link.sdata;
		d.dt_s2    = q.dt_s1;
		d.cmd_done = 1'b0;

		if (!q.io_s2 || !q.an_s2) begin
			// supplies down: everything off, contents lost
			d.mode   = PMSF_SHUTDOWN;
			// once io is seen low the chip stays armed, even through an analog dip
			d.armed  = q.armed | ~q.io_s2;
			d.boost  = 4'h0;
			d.oe     = 6'h00;
			d.pstate = PMSF_PS_SHUTDOWN;
			d.shreg  = 32'h0000_0000;
			d.cnt    = 6'h00;
		end else begin
			case (q.mode)
				PMSF_SHUTDOWN: begin
					// only a fresh low-to-high io supply starts the chip
					if (q.armed) begin
						d.mode   = PMSF_STARTUP;
						d.armed  = 1'b0;
						d.pstate = PMSF_PS_STARTUP;
					end
				end
				PMSF_STARTUP: begin
					// single step: defaults in, serial cleared, then active
					d.boost  = PMSF_BOOST_RESET;
					d.oe     = PMSF_OE_RESET;
					d.shreg  = 32'h0000_0000;
					d.cnt    = 6'h00;
					d.pstate = PMSF_PS_ACTIVE;
					d.mode   = PMSF_ACTIVE;
				end
				PMSF_ACTIVE,
				PMSF_LOWPWR: begin
					// serial stays live in low power; 3-wire frames only with select high
					if (cs_rise) begin
						d.shreg = 32'h0000_0000;
						d.cnt   = 6'h00;
					end else if (q.cs_s2 && ck_rise) begin
						d.shreg = {q.shreg[30:0], q.dt_s2};
						if (q.cnt != 6'h3F) begin
							d.cnt = q.cnt + 6'h01;
						end
					end
					// a frame of any length other than 30 or 32 fails the length check and is dropped
					if (cs_fall && len_ok) begin
						d.cmd_done = 1'b1;
						case (addr)
							PMSF_ADDR_BOOST: begin
								d.boost = wdata[3:0];
							end
							PMSF_ADDR_OE: begin
								d.oe = wdata[5:0];
							end
							PMSF_ADDR_PMODE: begin
								if (wdata[1:0] == PMSF_PS_STARTUP) begin
									d.mode   = PMSF_STARTUP;
									d.pstate = PMSF_PS_STARTUP;
								end else if (wdata[1:0] == PMSF_PS_LOWPWR
									&& q.mode == PMSF_ACTIVE) begin
									d.mode   = PMSF_LOWPWR;
									d.pstate = PMSF_PS_LOWPWR;
								end else if (wdata[1:0] == PMSF_PS_ACTIVE
									&& q.mode == PMSF_LOWPWR) begin
									d.mode   = PMSF_ACTIVE;
									d.pstate = PMSF_PS_ACTIVE;
								end
							end
							default: begin
								// other addresses belong to logic outside this block
							end
						endcase
						d.cnt = 6'h00;
					end
				end
				default: begin
					d.mode = PMSF_SHUTDOWN;
				end
			endcase
		end

		// outputs only drive in active mode; disabled or not active means high z
		d.en_out    = (d.mode == PMSF_ACTIVE) ? d.oe : 6'h00;
		d.hiz_out   = (d.mode == PMSF_ACTIVE) ? ~d.oe : 6'h3F;
		// hysteretic loop: low flag from comparator gates the boost switch
		d.boost_run = (d.mode == PMSF_ACTIVE || d.mode == PMSF_STARTUP) && q.vl_s2;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q         <= '0;
			q.mode    <= PMSF_SHUTDOWN;
			q.pstate  <= PMSF_PS_SHUTDOWN;
			q.hiz_out <= 6'h3F;
		end else begin
			q <= d;
		end
	end

	assign boost_level_o   = q.boost;
	assign power_state_o   = q.pstate;
	assign output_enable_o = q.en_out;
	assign out_hiz_o       = q.hiz_out;
	assign boost_run_o     = q.boost_run;
	assign cmd_done_o      = q.cmd_done;

endmodule : pmsf_device

// File: pmsf_host.sv
// host end: apb-programmed 3-wire serial frame sender
`timescale 1ns/1ps
module pmsf_host (
	input  wire logic           clk_i,
	input  wire logic           reset_n_i,
	input  wire logic           psel_i,
	input  wire logic           penable_i,
	input  wire logic           pwrite_i,
	input  wire logic  [7:0]    paddr_i,
	input  wire logic  [31:0]   pwdata_i,
	output logic       [31:0]   prdata_o,
	output logic                pready_o,
	output logic                pslverr_o,
	pmsf_link_if.host           link
);
	import pmsf_pkg::*;

	typedef struct packed {
		pmsf_hstate_t st;
		logic [31:0]  txdata;
		logic [5:0]   len;
		logic [31:0]  sh;
		logic [5:0]   left;
		logic [2:0]   tick;
		logic         cs;
		logic         sclk;
		logic         sdata;
		logic [31:0]  prdata;
		logic         pready;
	} pmsf_host_t;

	pmsf_host_t q;
	pmsf_host_t d;

	logic setup;
	logic wr;
	logic half;

	always_comb begin
		setup = psel_i && !penable_i;
		wr    = psel_i && penable_i && pwrite_i && q.pready;
		half  = (q.tick == 3'(PMSF_HALF_CYC - 1));

		d = q;
		// pready rises for the access cycle that follows each setup cycle
		d.pready = setup;
		if (setup) begin
			case (paddr_i)
				PMSF_HOST_CTRL:   d.prdata = {26'h0, q.len};
				PMSF_HOST_TXDATA: d.prdata = q.txdata;
				PMSF_HOST_STATUS: d.prdata = {31'h0, q.st != PMSF_H_IDLE};
				default:          d.prdata = 32'h0000_0000;
			endcase
		end
		d.tick = half ? 3'h0 : q.tick + 3'h1;

		case (q.st)
			PMSF_H_IDLE: begin
				d.cs   = 1'b0;
				d.sclk = 1'b0;
				d.tick = 3'h0;
				if (wr && paddr_i == PMSF_HOST_TXDATA) begin
					d.txdata = pwdata_i;
				end
				// a go write with length zero is dropped; no write reaches a busy host
				if (wr && paddr_i == PMSF_HOST_CTRL) begin
					d.len = pwdata_i[5:0];
					if (pwdata_i[PMSF_CTRL_GO] && pwdata_i[5:0] != 6'h00) begin
						// left-justify so the msb of the frame goes out first
						d.sh   = q.txdata << (6'h20 - {1'b0, pwdata_i[5:0]});
						d.left = pwdata_i[5:0];
						d.cs   = 1'b1;
						d.st   = PMSF_H_SETUP;
					end
				end
			end
			PMSF_H_SETUP: begin
				if (half) begin
					d.sdata = q.sh[31];
					d.sh    = {q.sh[30:0], 1'b0};
					d.st    = PMSF_H_LOW;
				end
			end
			PMSF_H_LOW: begin
				if (half) begin
					d.sclk = 1'b1;
					d.left = q.left - 6'h01;
					d.st   = PMSF_H_HIGH;
				end
			end
			PMSF_H_HIGH: begin
				if (half) begin
					d.sclk = 1'b0;
					if (q.left == 6'h00) begin
						d.st = PMSF_H_HOLD;
					end else begin
						d.sdata = q.sh[31];
						d.sh    = {q.sh[30:0], 1'b0};
						d.st    = PMSF_H_LOW;
					end
				end
			end
			PMSF_H_HOLD: begin
				if (half) begin
					d.cs    = 1'b0;
					d.sdata = 1'b0;
					d.st    = PMSF_H_GAP;
				end
			end
			PMSF_H_GAP: begin
				// select low gap so the device sees the frame end
				if (half) begin
					d.st = PMSF_H_IDLE;
				end
			end
			default: begin
				d.st = PMSF_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q    <= '0;
			q.st <= PMSF_H_IDLE;
		end else begin
			q <= d;
		end
	end

	// write-only link: the data pin is never read back
	assign link.cs    = q.cs;
	assign link.sclk  = q.sclk;
	assign link.sdata = q.sdata;
	assign prdata_o   = q.prdata;
	assign pready_o   = q.pready;
	assign pslverr_o  = 1'b0;

endmodule : pmsf_host

// File: pmsf_sva.sv
// concurrent checks on the serial link and the device mode outputs
`timescale 1ns/1ps
module pmsf_sva
	import pmsf_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       cs,
	input wire logic       sclk,
	input wire logic       sdata,
	input wire logic       io_supply_i,
	input wire logic       analog_supply_i,
	input wire logic [1:0] power_state_o,
	input wire logic [5:0] output_enable_o,
	input wire logic [5:0] out_hiz_o,
	input wire logic       cmd_done_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_sclk_idle: assert property (!cs |-> !sclk)
		else $error("serial clock moved outside a frame");
	a_sclk_half: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
		else $error("serial clock high half is not four cycles");
	a_data_steady: assert property (sclk |-> $stable(sdata))
		else $error("data changed while serial clock high");
	a_hiz_inactive: assert property (power_state_o != PMSF_PS_ACTIVE |-> out_hiz_o == 6'h3F)
		else $error("outputs driven outside active mode");
	a_oe_inactive: assert property (power_state_o != PMSF_PS_ACTIVE |-> output_enable_o == 6'h00)
		else $error("enables set outside active mode");
	a_io_low_shut: assert property (!io_supply_i [*4] |-> power_state_o == PMSF_PS_SHUTDOWN)
		else $error("io supply low without shutdown");
	a_startup_step: assert property (power_state_o == PMSF_PS_STARTUP |=> power_state_o == PMSF_PS_ACTIVE)
		else $error("startup lasted more than one step");
	a_startup_time: assert property ($rose(io_supply_i) && analog_supply_i |-> ##[2:8] power_state_o == PMSF_PS_ACTIVE)
		else $error("active mode not reached after io rise");
	a_done_pulse: assert property (cmd_done_o |=> !cmd_done_o)
		else $error("done pulse longer than one cycle");
	a_done_after_cs: assert property (cmd_done_o |-> !cs && $past(cs, 2) == 1'b0)
		else $error("command executed before select fell");
endmodule : pmsf_sva

// File: pmsf_tb.sv
// self-checking bench joining host and device over the serial link
`timescale 1ns/1ps
module testbench;
	import pmsf_pkg::*;
	logic        clk_i, reset_n_i, psel, penable, pwrite, pready;
	logic        an_sup, io_sup, vlow, brun, done, cs_q, sclk_q, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, cap;
	logic [3:0]  boost, done_n;
	logic [1:0]  pstate;
	logic [5:0]  oe, hiz, bits_n;
	int          n_fail, samples_checked;

	pmsf_link_if lnk ();
	pmsf_host u_pmsf_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .link(lnk));
	pmsf_device u_pmsf_device (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.analog_supply_i(an_sup), .io_supply_i(io_sup), .boosted_voltage_low_i(vlow),
		.link(lnk), .boost_level_o(boost), .power_state_o(pstate), .output_enable_o(oe),
		.out_hiz_o(hiz), .boost_run_o(brun), .cmd_done_o(done));
	pmsf_sva u_pmsf_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs(lnk.cs), .sclk(lnk.sclk),
		.sdata(lnk.sdata), .io_supply_i(io_sup), .analog_supply_i(an_sup),
		.power_state_o(pstate), .output_enable_o(oe), .out_hiz_o(hiz), .cmd_done_o(done));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// wire monitor: counts rising serial clocks inside a frame and collects the bits
	always @(posedge clk_i) begin
		if (lnk.cs && !cs_q) begin
			bits_n <= 6'h00;
			cap    <= 32'h0;
		end else if (lnk.cs && lnk.sclk && !sclk_q) begin
			bits_n <= bits_n + 6'h01;
			cap    <= {cap[30:0], lnk.sdata};
		end
		cs_q   <= lnk.cs;
		sclk_q <= lnk.sclk;
		// done pulses seen since the last frame opened
		if (lnk.cs && !cs_q) begin
			done_n <= 4'h0;
		end else if (done) begin
			done_n <= done_n + 4'h1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] cmd(input logic [4:0] a, input logic [15:0] d);
		return {11'h000, a, d};
	endfunction : cmd

	task automatic frame(input logic [5:0] len, input logic [31:0] w);
		logic [31:0] m;
		logic        ok;
		// only a 30 or 32 bit frame in a live mode earns exactly one done pulse
		ok = (pstate == PMSF_PS_ACTIVE || pstate == PMSF_PS_LOWPWR)
			&& (len == 6'(PMSF_FRAME_SHORT) || len == 6'(PMSF_FRAME_LONG));
		apb(1'b1, PMSF_HOST_TXDATA, w);
		apb(1'b1, PMSF_HOST_CTRL, (32'h1 << PMSF_CTRL_GO) | {26'h0, len});
		do apb(1'b0, PMSF_HOST_STATUS, 32'h0); while (rd[0] !== 1'b0);
		repeat (8) @(posedge clk_i);
		chk({26'h0, bits_n}, {26'h0, len});
		m = 32'hFFFF_FFFF >> (6'h20 - len);
		if (len <= 6'h20) chk(cap & m, w & m);
		chk({28'h0, done_n}, {31'h0, ok});
	endtask : frame

	task automatic t_power;
		chk(pstate, PMSF_PS_SHUTDOWN);
		chk(hiz, 6'h3F);
		apb(1'b1, PMSF_HOST_CTRL, 32'h1E);
		apb(1'b0, PMSF_HOST_CTRL, 32'h0);
		chk(rd[5:0], 6'h1E);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, PMSF_HOST_TXDATA, 32'hA55A_0FF0);
		apb(1'b0, PMSF_HOST_TXDATA, 32'h0);
		chk(rd, 32'hA55A_0FF0);
		chk({31'h0, perr}, 32'h0);
		io_sup <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(pstate, PMSF_PS_ACTIVE);
		chk(boost, PMSF_BOOST_RESET);
		chk(oe, PMSF_OE_RESET);
		$display("test power done");
	endtask : t_power

	task automatic t_frames;
		frame(6'h20, cmd(PMSF_ADDR_BOOST, 16'h0005));
		chk(boost, 4'h5);
		frame(6'h1E, cmd(PMSF_ADDR_OE, 16'h002A));
		chk(oe, 6'h2A);
		chk(hiz, 6'h15);
		frame(6'h1F, cmd(PMSF_ADDR_BOOST, 16'h0009));
		chk(boost, 4'h5);
		frame(6'h21, cmd(PMSF_ADDR_BOOST, 16'h0009));
		chk(boost, 4'h5);
		vlow <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk(brun, 1'b1);
		vlow <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk(brun, 1'b0);
		$display("test frames done");
	endtask : t_frames

	task automatic t_modes;
		vlow <= 1'b1;
		frame(6'h20, cmd(PMSF_ADDR_PMODE, 16'h0002));
		chk(pstate, PMSF_PS_LOWPWR);
		chk(brun, 1'b0);
		frame(6'h20, cmd(PMSF_ADDR_PMODE, 16'h0003));
		chk(pstate, PMSF_PS_LOWPWR);
		frame(6'h1E, cmd(PMSF_ADDR_PMODE, 16'h0000));
		chk(pstate, PMSF_PS_ACTIVE);
		chk(brun, 1'b1);
		frame(6'h20, cmd(PMSF_ADDR_PMODE, 16'h0001));
		chk(boost, PMSF_BOOST_RESET);
		chk(oe, PMSF_OE_RESET);
		vlow <= 1'b0;
		$display("test modes done");
	endtask : t_modes

	task automatic t_shut;
		an_sup <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk(pstate, PMSF_PS_SHUTDOWN);
		chk(hiz, 6'h3F);
		// analog back with io still high: no new power-on reset without an io low
		an_sup <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(pstate, PMSF_PS_SHUTDOWN);
		io_sup <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk(pstate, PMSF_PS_SHUTDOWN);
		frame(6'h20, cmd(PMSF_ADDR_BOOST, 16'h0007));
		chk(boost, 4'h0);
		io_sup <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(pstate, PMSF_PS_ACTIVE);
		chk(boost, PMSF_BOOST_RESET);
		$display("test shutdown done");
	endtask : t_shut

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{an_sup, io_sup, vlow, reset_n_i} = 4'h8;
		n_fail = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		t_power;
		t_frames;
		t_modes;
		t_shut;
		close_out;
	end

	initial begin
		#200us;
		n_fail++;
		close_out;
	end
endmodule : testbench
